// [include/i2cx_pkg.sv]
// i2cx_pkg: register map, field positions and reset values
// assumes a 32-bit register port with byte offsets
package i2cx_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_SOURCE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_EXT_MODE   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_PIN_FUNC   = 8'h48;

  // field positions
  localparam int unsigned BIT_STOP_DET  = 5;
  localparam int unsigned BIT_SLAVE_TX  = 14;
  localparam int unsigned BIT_STOP_EN   = 5;
  localparam int unsigned BIT_TX_MODE   = 0;
  localparam int unsigned BIT_GPIO_SEL  = 0;
  localparam int unsigned CODE_W        = 3;

  // interrupt source codes: none, and the one reported for a detected stop
  localparam logic [CODE_W-1:0] CODE_NONE = 3'h0;
  localparam logic [CODE_W-1:0] CODE_STOP = 3'h6;

  // reset values
  localparam logic RST_TX_MODE  = 1'h1;
  localparam logic RST_GPIO_SEL = 1'h0;
  localparam logic RST_STOP_EN  = 1'h0;
  localparam logic RST_FLAG     = 1'h0;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// [hdl/i2cx_status_ext.sv]
// i2cx_status_ext: status flags, transmit-ready mode and pin function
// select added beside a two-wire bus controller core.
// assumes the core runs on clk_i and pins are asynchronous to it.
`timescale 1ns/10ps

module i2cx_status_ext
  import i2cx_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [i2cx_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [i2cx_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                        wr_en_i,
  input  wire logic                        rd_en_i,
  output logic      [i2cx_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                        sda_i,
  input  wire logic                        scl_i,
  input  wire logic                        slave_tx_role_i,
  input  wire logic                        loopback_i,
  input  wire logic                        slave_addr_rd_i,
  input  wire logic                        on_master_ack_i,
  input  wire logic                        on_holding_copy_i,
  input  wire logic                        core_sda_low_i,
  input  wire logic                        core_scl_low_i,
  input  wire logic                        gpio_sda_dir_i,
  input  wire logic                        gpio_scl_dir_i,
  input  wire logic                        gpio_sda_out_i,
  input  wire logic                        gpio_scl_out_i,
  output logic                             sda_o,
  output logic                             sda_oe_o,
  output logic                             scl_o,
  output logic                             scl_oe_o,
  output logic                             tx_ready_o,
  output logic                             stop_irq_o,
  output logic                             pin_gpio_select_o,
  output logic                             tx_ready_mode_select_o
);
  import i2cx_pkg::*;

  logic [1:0]        sda_sync_r;
  logic [1:0]        scl_sync_r;
  logic              sda_prev_r;
  logic              scl_prev_r;
  logic              start_seen;
  logic              stop_seen;
  logic              slave_tx_direction_flag_r;
  logic              slave_tx_direction_nxt;
  logic              stop_detected_flag_r;
  logic              stop_detected_nxt;
  logic              stop_irq_enable_r;
  logic              tx_ready_mode_select_r;
  logic              pin_gpio_select_r;
  logic              wr_status;
  logic              rd_source;
  logic [CODE_W-1:0] interrupt_code_field;
  logic              tx_ready_nxt;
  logic [DATA_W-1:0] rd_nxt;

  // pins: two flops, then one more stage for edge finding
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_sync_r <= 2'h3;
      scl_sync_r <= 2'h3;
      sda_prev_r <= 1'h1;
      scl_prev_r <= 1'h1;
    end else begin
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_prev_r <= sda_sync_r[1];
      scl_prev_r <= scl_sync_r[1];
    end
  end

  // sda edge while scl stays high
  assign start_seen = scl_sync_r[1] && scl_prev_r && sda_prev_r
                      && !sda_sync_r[1];
  assign stop_seen  = scl_sync_r[1] && scl_prev_r && !sda_prev_r
                      && sda_sync_r[1];

  assign wr_status = wr_en_i && (addr_i == OFS_STATUS);
  assign rd_source = rd_en_i && (addr_i == OFS_IRQ_SOURCE);

  assign interrupt_code_field = (stop_detected_flag_r && stop_irq_enable_r)
                                ? CODE_STOP : CODE_NONE;

  // slave-transmit direction flag
  always_comb begin
    slave_tx_direction_nxt = slave_tx_direction_flag_r;
    if (start_seen || stop_seen) begin
      slave_tx_direction_nxt = 1'b0;
    end
    if (wr_status && wr_data_i[BIT_SLAVE_TX]) begin
      slave_tx_direction_nxt = 1'b0;
    end
    if (!slave_tx_role_i) begin
      slave_tx_direction_nxt = 1'b0;
    end
    if (slave_addr_rd_i) begin
      slave_tx_direction_nxt = 1'b1;
    end
    if (loopback_i) begin
      slave_tx_direction_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slave_tx_direction_flag_r <= RST_FLAG;
    end else begin
      slave_tx_direction_flag_r <= slave_tx_direction_nxt;
    end
  end

  // stop-detected flag
  always_comb begin
    stop_detected_nxt = stop_detected_flag_r;
    if (wr_status && wr_data_i[BIT_STOP_DET]) begin
      stop_detected_nxt = 1'b0;
    end
    if (rd_source && (interrupt_code_field == CODE_STOP)) begin
      stop_detected_nxt = 1'b0;
    end
    if (stop_seen) begin
      stop_detected_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_detected_flag_r <= RST_FLAG;
    end else begin
      stop_detected_flag_r <= stop_detected_nxt;
    end
  end

  // software-written control bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stop_irq_enable_r      <= RST_STOP_EN;
      tx_ready_mode_select_r <= RST_TX_MODE;
      pin_gpio_select_r      <= RST_GPIO_SEL;
    end else if (wr_en_i) begin
      if (addr_i == OFS_IRQ_ENABLE) begin
        stop_irq_enable_r <= wr_data_i[BIT_STOP_EN];
      end
      if (addr_i == OFS_EXT_MODE) begin
        tx_ready_mode_select_r <= wr_data_i[BIT_TX_MODE];
      end
      if (addr_i == OFS_PIN_FUNC) begin
        pin_gpio_select_r <= wr_data_i[BIT_GPIO_SEL];
      end
    end
  end

  // transmit data ready event
  always_comb begin
    tx_ready_nxt = on_holding_copy_i;
    if (slave_tx_role_i && !tx_ready_mode_select_r) begin
      tx_ready_nxt = slave_addr_rd_i || on_master_ack_i;
    end else if (slave_tx_role_i) begin
      tx_ready_nxt = on_holding_copy_i;
    end else begin
      tx_ready_nxt = on_holding_copy_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_ready_o <= 1'b0;
      stop_irq_o <= 1'b0;
    end else begin
      tx_ready_o <= tx_ready_nxt;
      stop_irq_o <= stop_detected_nxt && stop_irq_enable_r;
    end
  end

  // read mux; unmapped and idle cycles return zero
  always_comb begin
    rd_nxt = ZERO_WORD;
    if (rd_en_i) begin
      case (addr_i)
        OFS_IRQ_ENABLE: rd_nxt[BIT_STOP_EN] = stop_irq_enable_r;
        OFS_STATUS: begin
          rd_nxt[BIT_SLAVE_TX] = slave_tx_direction_flag_r;
          rd_nxt[BIT_STOP_DET] = stop_detected_flag_r;
        end
        OFS_IRQ_SOURCE: rd_nxt[CODE_W-1:0] = interrupt_code_field;
        OFS_EXT_MODE: begin
          rd_nxt[BIT_TX_MODE] = tx_ready_mode_select_r;
        end
        OFS_PIN_FUNC: begin
          rd_nxt[BIT_GPIO_SEL] = pin_gpio_select_r;
        end
        default: rd_nxt = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= ZERO_WORD;
    end else begin
      rd_data_o <= rd_nxt;
    end
  end

  // pin ownership: open-drain bus use or gpio push-pull
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      scl_o    <= 1'b0;
      scl_oe_o <= 1'b0;
    end else if (pin_gpio_select_r) begin
      sda_o    <= gpio_sda_out_i;
      sda_oe_o <= gpio_sda_dir_i;
      scl_o    <= gpio_scl_out_i;
      scl_oe_o <= gpio_scl_dir_i;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= core_sda_low_i;
      scl_o    <= 1'b0;
      scl_oe_o <= core_scl_low_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_gpio_select_o      <= RST_GPIO_SEL;
      tx_ready_mode_select_o <= RST_TX_MODE;
    end else begin
      pin_gpio_select_o      <= pin_gpio_select_r;
      tx_ready_mode_select_o <= tx_ready_mode_select_r;
    end
  end

endmodule // i2cx_status_ext

// [verif/i2cx_checker.sv]
// i2cx_checker: port assertions for the status extension
// assumes binding onto i2cx_status_ext, one clock domain
`timescale 1ns/10ps
module i2cx_checker
  import i2cx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [i2cx_pkg::ADDR_W-1:0] addr_i,
  input wire logic rd_en_i,
  input wire logic [i2cx_pkg::DATA_W-1:0] rd_data_o,
  input wire logic slave_tx_role_i,
  input wire logic on_master_ack_i,
  input wire logic on_holding_copy_i,
  input wire logic core_sda_low_i,
  input wire logic core_scl_low_i,
  input wire logic gpio_sda_dir_i,
  input wire logic gpio_sda_out_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic tx_ready_o,
  input wire logic pin_gpio_select_o,
  input wire logic tx_ready_mode_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  st_rsv_a: assert property (
    $past(rd_en_i) && $past(addr_i) == OFS_STATUS |->
    rd_data_o[31:15] == 17'h0 && rd_data_o[7:6] == 2'h0)
    else $error("status reserved bits set");
  emode_rd_a: assert property (
    $past(rd_en_i) && $past(addr_i) == OFS_EXT_MODE |->
    rd_data_o == {31'h0, tx_ready_mode_select_o})
    else $error("ext mode readback wrong");
  pfunc_rd_a: assert property (
    $past(rd_en_i) && $past(addr_i) == OFS_PIN_FUNC |->
    rd_data_o[0] == pin_gpio_select_o)
    else $error("pin select readback wrong");
  gpio_drv_a: assert property (
    $past(pin_gpio_select_o) && pin_gpio_select_o |->
    sda_oe_o == $past(gpio_sda_dir_i) && sda_o == $past(gpio_sda_out_i))
    else $error("gpio drive wrong");
  bus_drv_a: assert property (
    !$past(pin_gpio_select_o) && !pin_gpio_select_o |-> !sda_o && !scl_o
    && sda_oe_o == $past(core_sda_low_i) && scl_oe_o == $past(core_scl_low_i))
    else $error("bus drive wrong");
  copy_rdy_a: assert property (
    $past(on_holding_copy_i && tx_ready_mode_select_o) |-> tx_ready_o)
    else $error("no ready on copy");
  m1_quiet_a: assert property (
    $past(tx_ready_mode_select_o && !on_holding_copy_i) |-> !tx_ready_o)
    else $error("spurious ready");
  ack_rdy_a: assert property (
    $past(on_master_ack_i && slave_tx_role_i && !tx_ready_mode_select_o)
    |-> tx_ready_o)
    else $error("no ready on ack");
  role_ign_a: assert property (
    $past(on_holding_copy_i && !slave_tx_role_i) |-> tx_ready_o)
    else $error("mode not ignored");
endmodule // i2cx_checker

bind i2cx_status_ext i2cx_checker chk_u (.*);

// [verif/i2cx_bus_model.sv]
// i2cx_bus_model: another bus party making start and stop
// assumes pulled-up lines; clock parked outside frames
`timescale 1ns/10ps
module i2cx_bus_model (
  output logic sda_o,
  output logic scl_o
);
  initial begin
    sda_o = 1'b1;
    scl_o = 1'b1;
  end
  task automatic start_cond();
    sda_o = 1'b0;
    #200 scl_o = 1'b0;
  endtask
  // sda rises while scl high
  task automatic stop_cond();
    sda_o = 1'b0;
    #200 scl_o = 1'b1;
    #200 sda_o = 1'b1;
  endtask
endmodule // i2cx_bus_model

// [verif/test_i2cx_status_ext.sv]
// test_i2cx_status_ext: self-checking bench with register model
// assumes bus model on the wire and the bound checker
`timescale 1ns/10ps
module test_i2cx_status_ext;
  import i2cx_pkg::*;
  logic clk_i, rst_b_i, wr_en_i, rd_en_i, loopback_i, slave_tx_role_i;
  logic [7:0] addr_i;
  logic [31:0] wr_data_i, rd_data_o, m_st;
  logic sda_i, scl_i, bm_sda, bm_scl, core_sda_low_i, core_scl_low_i;
  logic slave_addr_rd_i, on_master_ack_i, on_holding_copy_i;
  logic gpio_sda_dir_i, gpio_scl_dir_i, gpio_sda_out_i, gpio_scl_out_i;
  logic sda_o, sda_oe_o, scl_o, scl_oe_o, tx_ready_o, stop_irq_o;
  logic pin_gpio_select_o, tx_ready_mode_select_o, m_en, m_mode, m_gp;
  logic [2:0] ev;
  logic [3:0] gp;
  int fail_count, checks;
  assign {slave_addr_rd_i, on_master_ack_i, on_holding_copy_i} = ev;
  assign {gpio_sda_dir_i, gpio_scl_dir_i, gpio_sda_out_i, gpio_scl_out_i} = gp;
  assign sda_i = sda_oe_o ? sda_o & bm_sda : bm_sda;
  assign scl_i = scl_oe_o ? scl_o & bm_scl : bm_scl;
  i2cx_status_ext uut (.*);
  i2cx_bus_model bm (.sda_o(bm_sda), .scl_o(bm_scl));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_of(input logic [7:0] a);
    case (a)
      OFS_STATUS: return m_st;
      OFS_IRQ_ENABLE: return {26'h0, m_en, 5'h0};
      OFS_IRQ_SOURCE: return (m_st[5] && m_en) ? 32'h6 : 32'h0;
      OFS_EXT_MODE: return {31'h0, m_mode};
      OFS_PIN_FUNC: return {31'h0, m_gp};
      default: return 32'h0;
    endcase
  endfunction
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    e = exp_of(a);
    @(posedge clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk(a == OFS_PIN_FUNC ? rd_data_o & 32'h1 : rd_data_o, e);
    if (e == 32'h6 && a == OFS_IRQ_SOURCE) m_st[5] = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
    if (a == OFS_STATUS) m_st = m_st & ~(d & 32'h4020);
    if (a == OFS_IRQ_ENABLE) m_en = d[5];
    if (a == OFS_EXT_MODE) m_mode = d[0];
    if (a == OFS_PIN_FUNC) m_gp = d[0];
  endtask
  task automatic pulse(input logic [2:0] k, input logic e);
    @(posedge clk_i);
    ev <= k;
    @(posedge clk_i);
    ev <= 3'h0;
    #1;
    if (k[2] && slave_tx_role_i && !loopback_i) m_st[14] = 1'b1;
    chk(tx_ready_o, e);
  endtask
  task automatic cond(input logic s);
    if (s) bm.stop_cond();
    else bm.start_cond();
    repeat (6) @(posedge clk_i);
    m_st[14] = 1'b0;
    if (s) m_st[5] = 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    fail_count++;
    end_sim();
  end
  initial begin
    void'($urandom(59));
    {rst_b_i, wr_en_i, rd_en_i, loopback_i, slave_tx_role_i} = 5'h0;
    {addr_i, wr_data_i, ev, gp, core_sda_low_i, core_scl_low_i} = 0;
    {m_st, m_en, m_mode, m_gp} = 35'h2;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(OFS_STATUS);
    rd(OFS_EXT_MODE);
    rd(OFS_PIN_FUNC);
    rd(OFS_IRQ_ENABLE);
    rd(8'h30);
    repeat (4) begin
      wr(OFS_EXT_MODE, $urandom());
      rd(OFS_EXT_MODE);
    end
    cond(1'b1);
    rd(OFS_STATUS);
    chk(stop_irq_o, 1'b0);
    wr(OFS_STATUS, 32'hFFFF_BFDF);
    rd(OFS_STATUS);
    wr(OFS_IRQ_ENABLE, 32'h20);
    rd(OFS_IRQ_ENABLE);
    chk(stop_irq_o, 1'b1);
    rd(OFS_IRQ_SOURCE);
    rd(OFS_STATUS);
    cond(1'b1);
    wr(OFS_STATUS, 32'h20);
    rd(OFS_STATUS);
    slave_tx_role_i <= 1'b1;
    wr(OFS_EXT_MODE, 32'h0);
    pulse(3'h4, 1'b1);
    rd(OFS_STATUS);
    pulse(3'h2, 1'b1);
    pulse(3'h1, 1'b0);
    cond(1'b0);
    rd(OFS_STATUS);
    pulse(3'h4, 1'b1);
    wr(OFS_STATUS, 32'h4000);
    rd(OFS_STATUS);
    pulse(3'h4, 1'b1);
    loopback_i <= 1'b1;
    m_st[14] = 1'b0;
    rd(OFS_STATUS);
    pulse(3'h4, 1'b1);
    rd(OFS_STATUS);
    loopback_i <= 1'b0;
    fork
      wr(OFS_STATUS, 32'h4000);
      pulse(3'h4, 1'b1);
    join
    rd(OFS_STATUS);
    slave_tx_role_i <= 1'b0;
    m_st[14] = 1'b0;
    rd(OFS_STATUS);
    pulse(3'h1, 1'b1);
    pulse(3'h2, 1'b0);
    wr(OFS_EXT_MODE, 32'h1);
    slave_tx_role_i <= 1'b1;
    pulse(3'h1, 1'b1);
    pulse(3'h2, 1'b0);
    slave_tx_role_i <= 1'b0;
    // module run bit is already clear on the core side
    wr(OFS_PIN_FUNC, 32'hFFFF_FFFF);
    rd(OFS_PIN_FUNC);
    repeat (4) begin
      gp <= 4'($urandom());
      repeat (2) @(posedge clk_i);
      #1;
      chk({sda_oe_o, scl_oe_o, sda_o, scl_o}, gp);
    end
    wr(OFS_PIN_FUNC, 32'hFFFF_FFFE);
    core_sda_low_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk({sda_oe_o, sda_o, scl_oe_o}, 3'h4);
    end_sim();
  end
endmodule // test_i2cx_status_ext
